// ---- shared/ivm_defines.svh ----
// constants for the interrupt vector mapping block
`ifndef IVM_DEFINES_SVH
`define IVM_DEFINES_SVH
`define IVM_NUM_VEC      24
`define IVM_VEC_W        5
`define IVM_ADDR_W       8
`define IVM_VEC_RESET    5'h00
`define IVM_VEC_NMI      5'h01
`define IVM_VEC_VLM      5'h02
`define IVM_VEC_RTC      5'h03
`define IVM_VEC_TICK     5'h04
`define IVM_VEC_CCL      5'h05
`define IVM_VEC_PA       5'h06
`define IVM_VEC_TA_OVF   5'h07
`define IVM_VEC_TA_UNF   5'h08
`define IVM_VEC_TA_CMP0  5'h09
`define IVM_VEC_TA_CMP1  5'h0A
`define IVM_VEC_TA_CMP2  5'h0B
`define IVM_VEC_TB0      5'h0C
`define IVM_VEC_TB1      5'h0D
`define IVM_VEC_TW_TGT   5'h0E
`define IVM_VEC_TW_CTL   5'h0F
`define IVM_VEC_SPI      5'h10
`define IVM_VEC_SP_RXC   5'h11
`define IVM_VEC_SP_DRE   5'h12
`define IVM_VEC_SP_TXC   5'h13
`define IVM_VEC_PD       5'h14
`define IVM_VEC_CMP      5'h15
`define IVM_VEC_CNV_RDY  5'h16
`define IVM_VEC_CNV_WIN  5'h17
`define IVM_VEC_FIRST_MASK 5'h02
`define IVM_REQ_ZERO     24'h00_0000
`define IVM_ADDR_ZERO    8'h00
`define IVM_VEC_ZERO     5'h00
`endif

// ---- shared/ivm_pkg.sv ----
// types for the interrupt vector mapping block
package ivm_pkg;
   typedef enum logic [2:0] {
      IVM_IDLE    = 3'b001,
      IVM_PRESENT = 3'b010,
      IVM_WAIT    = 3'b100
   } ivm_state_t;
endpackage : ivm_pkg

// ---- rtl/ivm_prio_enc.sv ----
// lowest-number-first priority encoder over the request vector
`timescale 1ns/1ps
`include "ivm_defines.svh"
module ivm_prio_enc (
   // request side
   input  wire logic [`IVM_NUM_VEC-1:0] req,
   // result side
   output logic                         any,
   output logic [`IVM_VEC_W-1:0]        vec
);
   // scan from the top so the lowest set index wins last
   always_comb begin
      any = 1'b0;
      vec = `IVM_VEC_ZERO;
      for (int i = `IVM_NUM_VEC - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            vec = i[`IVM_VEC_W-1:0];
         end
      end
   end
endmodule : ivm_prio_enc

// ---- rtl/ivm_top.sv ----
// interrupt vector mapping: request gating and vector selection
`timescale 1ns/1ps
`include "ivm_defines.svh"
// Functional notes
// RL1: peripheral event sets its own flag bit
// RL2: each source has its own enable bit
// RL3: request only when enable and flag set
// RL4: request stays active until flag cleared
// RL5: global enable gates every maskable request
// RL6: vector address is twice vector number
// RL7: vector 0 reset, vector 1 crc nmi
// RL8: vector 2 voltage monitor, 5 custom logic
// RL9: vector 3 counter match, 4 periodic tick
// RL10: timer a vectors 7 to 11
// RL11: timer b 12,13; two-wire 14,15
// RL12: serial periph 16; serial port 17-19
// RL13: ports 6 and 20, comparator 21
// RL14: converter ready 22, window 23
// RL15: lowest pending vector number served first
module ivm_top
   import ivm_pkg::*;
(
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   // global enable from the core status
   input  wire logic                     global_int_en,
   // crc scan non-maskable request
   input  wire logic                     crc_nmi_flag,
   // peripheral flags, one per source (set by the peripheral)
   // voltage level monitor
   input  wire logic                     vlm_flag,
   input  wire logic                     vlm_en,
   // real-time counter match and periodic tick
   input  wire logic                     rtc_flag,
   input  wire logic                     rtc_en,
   input  wire logic                     tick_flag,
   input  wire logic                     tick_en,
   // custom logic unit
   input  wire logic                     ccl_flag,
   input  wire logic                     ccl_en,
   // pin port a
   input  wire logic                     pa_flag,
   input  wire logic                     pa_en,
   // timer a: overflow, underflow, compare 0 to 2
   input  wire logic [4:0]               ta_flag,
   input  wire logic [4:0]               ta_en,
   // timer b units zero and one, capture
   input  wire logic [1:0]               tb_flag,
   input  wire logic [1:0]               tb_en,
   // two-wire port: target, controller
   input  wire logic [1:0]               tw_flag,
   input  wire logic [1:0]               tw_en,
   // serial peripheral port zero
   input  wire logic                     spi_flag,
   input  wire logic                     spi_en,
   // serial port zero: rx done, data empty, tx done
   input  wire logic [2:0]               sp_flag,
   input  wire logic [2:0]               sp_en,
   // pin port d
   input  wire logic                     pd_flag,
   input  wire logic                     pd_en,
   // analog comparator
   input  wire logic                     cmp_flag,
   input  wire logic                     cmp_en,
   // converter: result ready, window compare
   input  wire logic [1:0]               cnv_flag,
   input  wire logic [1:0]               cnv_en,
   // core handshake
   output logic                          irq_valid,
   input  wire logic                     irq_ack,
   output logic [`IVM_VEC_W-1:0]         irq_vector,
   output logic [`IVM_ADDR_W-1:0]        irq_addr,
   output logic                          irq_is_nmi,
   // raw gated requests, one bit per vector
   output logic [`IVM_NUM_VEC-1:0]       req_lines
);
   // flags and enables gathered by vector number
   logic [`IVM_NUM_VEC-1:0] flag_vec;
   logic [`IVM_NUM_VEC-1:0] en_vec;
   logic [`IVM_NUM_VEC-1:0] level_req;
   logic [`IVM_NUM_VEC-1:0] gated_req;
   logic                    pend_any;
   logic [`IVM_VEC_W-1:0]   pend_vec;
   logic [`IVM_VEC_W-1:0]   held_vec;
   ivm_state_t              state;
   ivm_state_t              next_state;
   logic [`IVM_VEC_W-1:0]   next_held;
   logic                    held_live; // held slot still requesting

   // vector address is vector number doubled
   // vectors are one word apart, so a shift is all it takes
   function automatic logic [`IVM_ADDR_W-1:0] vec_to_addr(
      input logic [`IVM_VEC_W-1:0] v);
      vec_to_addr = {2'b00, v, 1'b0}; // RL6
   endfunction : vec_to_addr

   // slot 0 is reset entry and never requests
   // flags arrive from each peripheral's own register
   assign flag_vec = {cnv_flag,            // RL14
                      cmp_flag,            // RL13
                      pd_flag,             // RL13
                      sp_flag,             // RL12
                      spi_flag,            // RL12
                      tw_flag,             // RL11
                      tb_flag,             // RL11
                      ta_flag,             // RL10
                      pa_flag,             // RL13
                      ccl_flag,            // RL8
                      tick_flag,           // RL9
                      rtc_flag,            // RL9
                      vlm_flag,            // RL8
                      crc_nmi_flag,        // RL7
                      1'b0};               // RL1 RL7
   // enable bits per source; nmi cannot be masked
   // order must match the flag map bit for bit
   assign en_vec   = {cnv_en,              // vectors 23,22
                      cmp_en,              // vector 21
                      pd_en,               // vector 20
                      sp_en,               // vectors 19 to 17
                      spi_en,              // vector 16
                      tw_en,               // vectors 15,14
                      tb_en,               // vectors 13,12
                      ta_en,               // vectors 11 to 7
                      pa_en,               // vector 6
                      ccl_en,              // vector 5
                      tick_en,             // vector 4
                      rtc_en,              // vector 3
                      vlm_en,              // vector 2
                      1'b1,                // nmi, always enabled
                      1'b0};               // reset entry // RL2

   // level request: enable and flag together, no latching
   assign level_req = flag_vec & en_vec; // RL3 RL4

   // global enable gates all but the non-maskable slot
   assign gated_req = level_req &
      ({`IVM_NUM_VEC{global_int_en}} | `IVM_NUM_VEC'(`IVM_VEC_FIRST_MASK));
                                                      // RL5 RL7
   assign req_lines = gated_req;
   // held slot re-checked each cycle, so a cleared flag withdraws it
   assign held_live = gated_req[held_vec]; // RL4

   // lowest vector wins
   // fixed order: a busy low vector can starve higher ones
   ivm_prio_enc u_prio (
      .req (gated_req),
      .any (pend_any),
      .vec (pend_vec)
   ); // RL15

   // present one vector, hold it stable until the core acks
   // a newly raised lower vector waits: switching the vector
   // under a core that is already fetching would hand it a
   // torn address; the cost is one extra round of latency
   // the wait state gives the handler one cycle to clear its
   // flag before the next choice, so it is not served twice
   always_comb begin
      next_state = state;
      next_held  = held_vec;
      case (state)
         IVM_IDLE: begin
            if (pend_any) begin
               next_state = IVM_PRESENT;
               next_held  = pend_vec; // RL15
            end
         end
         IVM_PRESENT: begin
            // withdrawn requests are dropped, not served late
            if (!held_live) begin
               next_state = IVM_IDLE; // RL4
            end else if (irq_ack) begin
               next_state = IVM_WAIT;
            end
         end
         IVM_WAIT: begin
            // one quiet cycle so handler can clear the flag
            next_state = IVM_IDLE;
         end
         default: begin
            next_state = IVM_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // nothing held, nothing presented
         state    <= IVM_IDLE;
         held_vec <= `IVM_VEC_ZERO;
      end else begin
         // advance the handshake
         state    <= next_state;
         held_vec <= next_held;
      end
   end

   // outputs from the held vector
   assign irq_valid = (state == IVM_PRESENT) & held_live;
   // vector, address and nmi mark registered together
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // core sees the reset entry while in reset
         irq_vector <= `IVM_VEC_ZERO;
         irq_addr   <= `IVM_ADDR_ZERO;
         irq_is_nmi <= 1'b0;
      end else begin
         irq_vector <= next_held;
         irq_addr   <= vec_to_addr(next_held); // RL6
         irq_is_nmi <= (next_held == `IVM_VEC_NMI); // RL7
      end
   end
endmodule : ivm_top

// ---- testbench/ivm_chk.sv ----
// port checker for the interrupt vector mapping block
`timescale 1ns/1ps
`include "ivm_defines.svh"
module ivm_chk (
   // clock and reset
   input wire logic                    sys_clk,
   input wire logic                    rst_n,
   // request inputs watched
   input wire logic                    global_int_en,
   input wire logic                    crc_nmi_flag,
   input wire logic [4:0]              ta_flag,
   input wire logic [4:0]              ta_en,
   // core side
   input wire logic                    irq_valid,
   input wire logic                    irq_ack,
   input wire logic [`IVM_VEC_W-1:0]   irq_vector,
   input wire logic [`IVM_ADDR_W-1:0]  irq_addr,
   input wire logic                    irq_is_nmi,
   input wire logic [`IVM_NUM_VEC-1:0] req_lines
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // lowest set bit, scanned downwards so the last hit wins
   function automatic logic [4:0] low_of(input logic [23:0] r);
      low_of = 5'h00;
      for (int i = 23; i >= 0; i--)
         if (r[i]) low_of = 5'(i);
   endfunction : low_of
   AST_TA_GATE: assert property (req_lines[11:7] ==
      (ta_flag & ta_en & {5{global_int_en}})) else $error("gate wrong");
   AST_LOW_LINES: assert property (req_lines[1:0] ==
      {crc_nmi_flag, 1'b0}) else $error("nmi or reset line wrong");
   AST_MASKED: assert property (!global_int_en |->
      req_lines[23:2] == 22'h00_0000) else $error("mask leak");
   AST_ADDR: assert property (irq_valid |->
      irq_addr == {2'b00, irq_vector, 1'b0}) else $error("bad address");
   AST_NMI_FLAG: assert property (irq_valid |->
      irq_is_nmi == (irq_vector == 5'h01)) else $error("nmi flag");
   AST_HELD: assert property (irq_valid |->
      req_lines[irq_vector]) else $error("valid without request");
   AST_LOWEST: assert property ($rose(irq_valid) |->
      irq_vector == low_of($past(req_lines))) else $error("not lowest");
   AST_ACK_GAP: assert property (irq_valid && irq_ack |=>
      !irq_valid [*2]) else $error("no gap after ack");
   AST_NO_PREEMPT: assert property (irq_valid && !irq_ack |=>
      !irq_valid || irq_vector == $past(irq_vector)) else $error("preempt");
   AST_SERVE: assert property ((!irq_valid && |req_lines) [*3] |=>
      irq_valid) else $error("request not served");
endmodule : ivm_chk
bind ivm_top ivm_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
   .global_int_en(global_int_en), .crc_nmi_flag(crc_nmi_flag),
   .ta_flag(ta_flag), .ta_en(ta_en), .irq_valid(irq_valid),
   .irq_ack(irq_ack), .irq_vector(irq_vector), .irq_addr(irq_addr),
   .irq_is_nmi(irq_is_nmi), .req_lines(req_lines));

// ---- testbench/ivm_core_model.sv ----
// processor core model: acknowledges a presented vector after a delay
`timescale 1ns/1ps
module ivm_core_model (
   // clock
   input wire logic        sys_clk,
   // vector handshake
   input wire logic        irq_valid,
   input wire logic [3:0]  lat,
   output logic            irq_ack,
   output logic [7:0]      taken_cnt
);
   int wait_n = 0; // cycles the vector has stood unanswered
   initial irq_ack = 1'b0;
   initial taken_cnt = 8'h00;
   // ack is a one-edge pulse; a large lat stalls like a busy core
   always @(posedge sys_clk) begin
      if (irq_valid && irq_ack)
         taken_cnt <= taken_cnt + 8'h01;
      wait_n = (irq_valid && !irq_ack) ? wait_n + 1 : 0;
      irq_ack <= #1 (wait_n > lat);
   end
endmodule : ivm_core_model

// ---- testbench/test_interrupt_vector_mapping.sv ----
// self-checking bench for the interrupt vector mapping block
`timescale 1ns/1ps
module test_interrupt_vector_mapping;
   typedef struct packed {
      logic [23:0] fl;
      logic [23:0] en;
      logic        g;
   } ivm_row_t;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [23:0] fl = 24'h00_0000; // flags, bit n feeds vector n
   logic [23:0] en = 24'hFF_FFFF; // enables, same order
   logic        g = 1'b1;
   logic [3:0]  lat = 4'h1;
   logic        irq_valid, irq_ack, irq_is_nmi;
   logic [4:0]  irq_vector, n;
   logic [7:0]  irq_addr, taken_cnt, m;
   logic [23:0] req_lines, pend;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          k;
   // all-set drains vectors 1 to 23 in order; the second serves 2 before 23; the last three probe the gating
   ivm_row_t rows [5] = '{'{24'hFF_FFFE, 24'hFF_FFFF, 1'b1},
      '{24'h80_0004, 24'hFF_FFFF, 1'b1}, '{24'hFF_FFFE, 24'h00_0000, 1'b1},
      '{24'hFF_FFFE, 24'hFF_FFFF, 1'b0}, '{24'h00_0A00, 24'h00_0800, 1'b1}};
   ivm_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .global_int_en(g),
      .crc_nmi_flag(fl[1]), .vlm_flag(fl[2]), .vlm_en(en[2]),
      .rtc_flag(fl[3]), .rtc_en(en[3]), .tick_flag(fl[4]), .tick_en(en[4]),
      .ccl_flag(fl[5]), .ccl_en(en[5]), .pa_flag(fl[6]), .pa_en(en[6]),
      .ta_flag(fl[11:7]), .ta_en(en[11:7]), .tb_flag(fl[13:12]),
      .tb_en(en[13:12]), .tw_flag(fl[15:14]), .tw_en(en[15:14]),
      .spi_flag(fl[16]), .spi_en(en[16]), .sp_flag(fl[19:17]),
      .sp_en(en[19:17]), .pd_flag(fl[20]), .pd_en(en[20]),
      .cmp_flag(fl[21]), .cmp_en(en[21]), .cnv_flag(fl[23:22]),
      .cnv_en(en[23:22]), .irq_valid(irq_valid), .irq_ack(irq_ack),
      .irq_vector(irq_vector), .irq_addr(irq_addr),
      .irq_is_nmi(irq_is_nmi), .req_lines(req_lines));
   ivm_core_model core_u (.sys_clk(sys_clk), .irq_valid(irq_valid),
      .lat(lat), .irq_ack(irq_ack), .taken_cnt(taken_cnt));
   always #20 sys_clk = ~sys_clk;
   // hang guard, well above the few hundred cycles used
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // inputs always move one ns after the edge
   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic print_verdict();
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      fl = 24'hFF_FFFE;
      tick(19);
      chk(24'({irq_valid, irq_is_nmi, irq_vector, irq_addr}), 24'h00_0000);
      tick(1);
      rst_n = 1'b1;
      fl = 24'h00_0000;
      tick(1);
      foreach (rows[i]) begin
         {fl, en, g} = rows[i];
         pend = (fl & en & {24{g}}) | (fl & 24'h00_0002);
         tick(1);
         chk(req_lines, pend);
         while (pend != 24'h00_0000) begin
            for (k = 23; k >= 0; k--)
               if (pend[k]) n = 5'(k);
            for (k = 0; k < 20 && irq_valid !== 1'b1; k++) tick(1);
            chk(24'(irq_vector), 24'(n));
            chk(24'(irq_addr), 24'({n, 1'b0}));
            chk(24'(irq_is_nmi), 24'(n == 5'h01));
            for (k = 0; k < 40 && irq_valid !== 1'b0; k++) tick(1);
            fl[n] = 1'b0;
            pend[n] = 1'b0;
         end
         tick(4);
         chk(24'(irq_valid), 24'h00_0000);
      end
      // stalled core: no preemption, then a dropped request is released
      lat = 4'hF;
      en = 24'hFF_FFFF;
      fl = 24'h00_0200;
      tick(2);
      fl = 24'h00_0208;
      tick(3);
      chk(24'(irq_vector), 24'h00_0009);
      m = taken_cnt;
      fl = 24'h00_0008;
      tick(4);
      chk(24'(irq_vector), 24'h00_0003);
      chk(24'(taken_cnt), 24'(m));
      fl = 24'h00_0000;
      tick(4);
      // reset in mid-run while a vector stands, then re-arbitrate
      fl = 24'h00_0100;
      tick(2);
      rst_n = 1'b0;
      tick(1);
      chk(24'({irq_valid, irq_is_nmi, irq_vector, irq_addr}), 24'h00_0000);
      tick(1);
      rst_n = 1'b1;
      tick(1);
      chk(24'({irq_valid, irq_vector}), 24'({1'b1, 5'h08}));
      fl = 24'h00_0000;
      tick(4);
      print_verdict();
   end
endmodule : test_interrupt_vector_mapping
